// *** cmc_device.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Common mode from electrodes, reference or external
// - External switch closed forces reference switch open
// - With power bit high, external open means some source switch closed
// - Reference switch only with all electrodes open
// - Power bit low opens every path
// - No selections picks the fixed reference
// - Electrode bits close matching electrode switches when drive bit clear
// - External select closes only external switch
// - Open drive loop sets header fault flag
// - Fault detection independent of drive redirection
// - Ten-bit DAC code drives DC level
// - DAC offers sine and square test tones
// - DAC routed internally or to pin
// - Host gives four extra clocks after DAC write
// - Factory coefficients for three lowest gains
// - User coefficients override, held in gain registers
// - Correction applied to all delivered ECG data
// - Common electrode bit: 0 off, 1 on
module cmc_device #(
  parameter int TONE_HALF_CYCLES = cmc_pkg::SQUARE_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  cmc_link_if.device link,
  input wire logic drive_loop_open_i,
  input wire logic [cmc_pkg::NUM_FACTORY_GAINS-1:0][cmc_pkg::COEF_W-1:0] factory_coef_i,
  input wire logic ecg_valid_i,
  input wire logic [2:0] ecg_chan_i,
  input wire logic signed [cmc_pkg::DATA_W-1:0] ecg_data_i,
  output logic block_power_enable_o,
  output logic external_path_switch_o,
  output logic internal_reference_switch_o,
  output logic [cmc_pkg::NUM_ELEC-1:0] electrode_switch_o,
  output logic [cmc_pkg::NUM_ELEC-1:0] drive_route_o,
  output logic common_electrode_enable_o,
  output logic header_fault_o,
  output logic [cmc_pkg::DAC_W-1:0] cal_dac_code_o,
  output logic [1:0] cal_tone_sel_o,
  output logic cal_square_o,
  output logic cal_to_pin_o,
  output logic ecg_valid_o,
  output logic [2:0] ecg_chan_o,
  output logic signed [cmc_pkg::DATA_W-1:0] ecg_data_o
);
  import cmc_pkg::*;

  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_d;
    logic cs_s1, cs_s2;
    logic mosi_s1, mosi_s2;
    logic flt_s1, flt_s2;
    logic [CNT_W-1:0] bit_cnt;
    logic [FRAME_BITS-1:0] shift_in;
    logic [DATA_W-1:0] shift_out;
    logic miso;
    logic [DATA_W-1:0] ctl;
    logic [DATA_W-1:0] cmref;
    logic [DATA_W-1:0] dac_reg;
    logic dac_pending;
    logic [2:0] extra_cnt;
    logic [DAC_W-1:0] dac_code;
    logic [NUM_CH-1:0][COEF_W-1:0] user_coef;
    logic [NUM_CH-1:0] user_en;
    logic pwr, sw_ext, sw_ref, ce;
    logic [NUM_ELEC-1:0] sw_el, drv;
    logic fault;
    logic [31:0] tone_cnt;
    logic square;
    logic out_valid;
    logic [2:0] out_chan;
    logic [DATA_W-1:0] out_data;
  } cmc_dev_s;

  cmc_dev_s q, next_q;

  logic rise, fall;
  logic [FRAME_BITS-1:0] word;
  logic [ADDR_W-1:0] rd_addr, wr_addr;
  logic [DATA_W-1:0] rd_val;
  logic [NUM_ELEC-1:0] sel;
  logic [1:0] gain;
  logic [COEF_W-1:0] coef;
  logic signed [DATA_W+COEF_W-1:0] prod;
  logic [ADDR_W-1:0] gidx;

  //////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb begin
    rd_addr = q.shift_in[ADDR_W-1:0];
    gidx = rd_addr - ADDR_GAIN_BASE;
    rd_val = '0;
    if (rd_addr == ADDR_CHANNEL_CONTROL) begin
      rd_val = q.ctl;
    end else if (rd_addr == ADDR_CM_REF_CONTROL) begin
      rd_val = q.cmref;
    end else if (rd_addr == ADDR_CAL_DAC) begin
      rd_val = q.dac_reg;
    end else if (rd_addr >= ADDR_GAIN_BASE && gidx < ADDR_W'(NUM_CH)) begin
      rd_val[COEF_W-1:0] = q.user_coef[gidx[2:0]];
      rd_val[GAIN_USER_BIT] = q.user_en[gidx[2:0]];
    end else if (rd_addr == ADDR_STATUS) begin
      rd_val[ST_FAULT_BIT] = q.fault;
      rd_val[ST_PEND_BIT] = q.dac_pending;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Gain coefficient choice and correction product
  always_comb begin
    gain = q.ctl[CTL_GAIN_LSB +: 2];
    if (q.user_en[ecg_chan_i]) begin
      coef = q.user_coef[ecg_chan_i];
    end else if (gain != GAIN_TOP) begin
      coef = factory_coef_i[gain];
    end else begin
      coef = COEF_UNITY;
    end
    prod = ecg_data_i * $signed({1'b0, coef[COEF_W-2:0]});
  end

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;
    next_q.sclk_s1 = link.sclk;
    next_q.sclk_s2 = q.sclk_s1;
    next_q.sclk_d = q.sclk_s2;
    next_q.cs_s1 = link.cs_n;
    next_q.cs_s2 = q.cs_s1;
    next_q.mosi_s1 = link.mosi;
    next_q.mosi_s2 = q.mosi_s1;
    next_q.flt_s1 = drive_loop_open_i;
    next_q.flt_s2 = q.flt_s1;
    rise = q.sclk_s2 & ~q.sclk_d;
    fall = ~q.sclk_s2 & q.sclk_d;
    word = {q.shift_in[FRAME_BITS-2:0], q.mosi_s2};
    wr_addr = word[DATA_W +: ADDR_W];

    // Extra clocks count whether or not a frame is open
    if (rise && q.dac_pending) begin
      next_q.extra_cnt = q.extra_cnt + 3'h1;
      if (q.extra_cnt == 3'(DAC_EXTRA_CLOCKS - 1)) begin
        next_q.dac_pending = 1'b0;
        next_q.dac_code = q.dac_reg[DAC_CODE_LSB +: DAC_W];
      end
    end

    if (q.cs_s2) begin
      next_q.bit_cnt = '0;
      next_q.miso = 1'b0;
    end else if (rise) begin
      next_q.shift_in = word;
      next_q.bit_cnt = q.bit_cnt + CNT_W'(1);
      if (q.bit_cnt == CNT_W'(FRAME_BITS - 1) && word[WR_FLAG_BIT]) begin
        if (wr_addr == ADDR_CHANNEL_CONTROL) begin
          next_q.ctl = word[DATA_W-1:0];
        end else if (wr_addr == ADDR_CM_REF_CONTROL) begin
          next_q.cmref = word[DATA_W-1:0];
        end else if (wr_addr == ADDR_CAL_DAC) begin
          next_q.dac_reg = word[DATA_W-1:0];
          next_q.dac_pending = 1'b1;
          next_q.extra_cnt = '0;
        end else if (wr_addr >= ADDR_GAIN_BASE && (wr_addr - ADDR_GAIN_BASE) < ADDR_W'(NUM_CH)) begin
          next_q.user_coef[3'(wr_addr - ADDR_GAIN_BASE)] = word[COEF_W-1:0];
          next_q.user_en[3'(wr_addr - ADDR_GAIN_BASE)] = word[GAIN_USER_BIT];
        end
      end
    end else if (fall) begin
      if (q.bit_cnt == CNT_W'(HDR_BITS) && !q.shift_in[HDR_BITS-1]) begin
        next_q.miso = rd_val[DATA_W-1];
        next_q.shift_out = {rd_val[DATA_W-2:0], 1'b0};
      end else if (q.bit_cnt > CNT_W'(HDR_BITS)) begin
        next_q.miso = q.shift_out[DATA_W-1];
        next_q.shift_out = {q.shift_out[DATA_W-2:0], 1'b0};
      end
    end

    // Switch matrix, evaluated from the live register contents
    sel = q.cmref[CM_SEL_LSB +: NUM_ELEC];
    next_q.pwr = q.ctl[CTL_PWR_BIT];
    next_q.ce = q.cmref[CM_CE_BIT];
    next_q.sw_ext = 1'b0;
    next_q.sw_ref = 1'b0;
    next_q.sw_el = '0;
    next_q.drv = '0;
    if (!q.ctl[CTL_PWR_BIT]) begin
      next_q.ce = 1'b0;
    end else if (q.cmref[CM_EXT_BIT]) begin
      next_q.sw_ext = 1'b1;
    end else if (q.cmref[CM_DRV_BIT] || sel == '0) begin
      // Electrodes feed the drive amplifier; mid-level falls back to reference
      next_q.sw_ref = 1'b1;
      next_q.drv = q.cmref[CM_DRV_BIT] ? sel : '0;
    end else begin
      next_q.sw_el = sel;
    end

    // Comparator state is taken whatever the drive routing
    next_q.fault = q.flt_s2;

    if (q.dac_reg[DAC_MODE_LSB +: 2] == 2'(CMC_TONE_SQUARE_1HZ)) begin
      if (q.tone_cnt >= 32'(TONE_HALF_CYCLES - 1)) begin
        next_q.tone_cnt = '0;
        next_q.square = ~q.square;
      end else begin
        next_q.tone_cnt = q.tone_cnt + 32'h1;
      end
    end else begin
      next_q.tone_cnt = '0;
      next_q.square = 1'b0;
    end

    next_q.out_valid = ecg_valid_i;
    if (ecg_valid_i) begin
      next_q.out_chan = ecg_chan_i;
      next_q.out_data = prod[COEF_FRAC +: DATA_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.sclk_s1 <= 1'b0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.ctl <= CTL_RESET;
      q.cmref <= CM_RESET;
      q.dac_reg <= DAC_RESET;
    end else begin
      q <= next_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign link.miso = q.miso;
  assign block_power_enable_o = q.pwr;
  assign external_path_switch_o = q.sw_ext;
  assign internal_reference_switch_o = q.sw_ref;
  assign electrode_switch_o = q.sw_el;
  assign drive_route_o = q.drv;
  assign common_electrode_enable_o = q.ce;
  assign header_fault_o = q.fault;
  assign cal_dac_code_o = q.dac_code;
  assign cal_tone_sel_o = q.dac_reg[DAC_MODE_LSB +: 2];
  assign cal_square_o = q.square;
  assign cal_to_pin_o = q.dac_reg[DAC_ROUTE_BIT];
  assign ecg_valid_o = q.out_valid;
  assign ecg_chan_o = q.out_chan;
  assign ecg_data_o = q.out_data;
endmodule : cmc_device

// *** cmc_pkg.sv ***
package cmc_pkg;
  // Serial frame: write flag, 7-bit address, 24-bit data, MSB first
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 8;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 24;
  localparam int WR_FLAG_BIT = 31;
  localparam int CNT_W = 6;

  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_CONTROL = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_CM_REF_CONTROL = 7'h05;
  localparam logic [ADDR_W-1:0] ADDR_CAL_DAC = 7'h10;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_BASE = 7'h11;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h30;

  // channel_control fields
  localparam int CTL_PWR_BIT = 0;
  localparam int CTL_GAIN_LSB = 8;
  // common_mode_reference_control fields
  localparam int CM_EXT_BIT = 2;
  localparam int CM_DRV_BIT = 3;
  localparam int CM_CE_BIT = 8;
  localparam int CM_SEL_LSB = 19;
  localparam int NUM_ELEC = 5;
  // Calibration DAC register fields
  localparam int DAC_W = 10;
  localparam int DAC_CODE_LSB = 0;
  localparam int DAC_MODE_LSB = 12;
  localparam int DAC_ROUTE_BIT = 16;
  localparam int DAC_EXTRA_CLOCKS = 4;
  // Gain register fields
  localparam int NUM_CH = 5;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 14;
  localparam int GAIN_USER_BIT = 23;
  localparam int NUM_FACTORY_GAINS = 3;
  localparam logic [COEF_W-1:0] COEF_UNITY = 16'h4000;
  localparam logic [1:0] GAIN_TOP = 2'h3;
  // Status fields
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_PEND_BIT = 1;

  localparam logic [DATA_W-1:0] CTL_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] CM_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] DAC_RESET = 24'h000000;

  typedef enum logic [1:0] {
    CMC_TONE_DC,
    CMC_TONE_SINE_10HZ,
    CMC_TONE_SINE_150HZ,
    CMC_TONE_SQUARE_1HZ
  } cmc_tone_e;

  localparam int CLK_HZ = 25_000_000;
  localparam int SQUARE_HZ = 1;
  localparam int SQUARE_HALF_CYCLES = CLK_HZ / (2 * SQUARE_HZ);
  localparam int SCLK_HALF_CYCLES = 4;
endpackage : cmc_pkg

// *** cmc_link_if.sv ***
`timescale 1ns/100ps
interface cmc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : cmc_link_if

// *** cmc_host.sv ***
`timescale 1ns/100ps
module cmc_host #(
  parameter int HALF_CYCLES = cmc_pkg::SCLK_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  cmc_link_if.host link,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [cmc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cmc_pkg::DATA_W-1:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [cmc_pkg::DATA_W-1:0] rdata_o
);
  import cmc_pkg::*;

  typedef enum logic [1:0] {CMC_H_IDLE, CMC_H_RUN, CMC_H_GAP} cmc_host_state_e;

  typedef struct packed {
    cmc_host_state_e state;
    logic sclk, cs_n, mosi;
    logic miso_s1, miso_s2;
    logic [FRAME_BITS-1:0] word;
    logic [CNT_W-1:0] clocks;
    logic [CNT_W-1:0] total;
    logic [7:0] div;
    logic write;
    logic busy, done;
    logic [DATA_W-1:0] rdata;
  } cmc_host_s;

  cmc_host_s q, next_q;
  logic tick;

  always_comb begin
    next_q = q;
    next_q.miso_s1 = link.miso;
    next_q.miso_s2 = q.miso_s1;
    next_q.done = 1'b0;
    tick = (q.div == 8'(HALF_CYCLES - 1));
    next_q.div = tick ? 8'h00 : q.div + 8'h01;
    case (q.state)
      CMC_H_IDLE: begin
        next_q.div = '0;
        if (req_i) begin
          next_q.state = CMC_H_RUN;
          next_q.busy = 1'b1;
          next_q.cs_n = 1'b0;
          next_q.write = write_i;
          next_q.word = {write_i, addr_i, wdata_i};
          next_q.mosi = write_i;
          next_q.clocks = '0;
          // Calibration DAC writes carry the extra trailing clocks
          next_q.total = (write_i && addr_i == ADDR_CAL_DAC) ?
                         CNT_W'(FRAME_BITS + DAC_EXTRA_CLOCKS) : CNT_W'(FRAME_BITS);
        end
      end
      CMC_H_RUN: begin
        if (tick) begin
          if (!q.sclk) begin
            next_q.sclk = 1'b1;
          end else begin
            next_q.sclk = 1'b0;
            next_q.clocks = q.clocks + CNT_W'(1);
            next_q.word = {q.word[FRAME_BITS-2:0], 1'b0};
            next_q.mosi = q.word[FRAME_BITS-2];
            if (!q.write && q.clocks >= CNT_W'(HDR_BITS) && q.clocks < CNT_W'(FRAME_BITS)) begin
              next_q.rdata = {q.rdata[DATA_W-2:0], q.miso_s2};
            end
            if (q.clocks == q.total - CNT_W'(1)) begin
              next_q.state = CMC_H_GAP;
              next_q.cs_n = 1'b1;
              next_q.mosi = 1'b0;
            end
          end
        end
      end
      CMC_H_GAP: begin
        if (tick) begin
          next_q.state = CMC_H_IDLE;
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
        end
      end
      default: begin
        next_q.state = CMC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.state <= CMC_H_IDLE;
      q.cs_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.mosi = q.mosi;
  assign busy_o = q.busy;
  assign done_o = q.done;
  assign rdata_o = q.rdata;
endmodule : cmc_host

// *** cmc_chk.sv ***
`timescale 1ns/100ps
module cmc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic block_power_enable_o,
  input wire logic external_path_switch_o,
  input wire logic internal_reference_switch_o,
  input wire logic [4:0] electrode_switch_o,
  input wire logic [9:0] cal_dac_code_o
);
  logic [5:0] rises;

  // Rises counted per frame, so the extra DAC clocks are seen in the count
  always_ff @(posedge clk_i) begin
    if (rst_i || $fell(cs_n)) begin
      rises <= 6'h00;
    end else if ($rose(sclk)) begin
      rises <= rises + 6'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////
  chk_ext_not_ref: assert property (external_path_switch_o |-> !internal_reference_switch_o)
    else $error("reference and external switches both closed");
  chk_node_driven: assert property (block_power_enable_o && $past(block_power_enable_o) &&
    !external_path_switch_o |-> internal_reference_switch_o || (electrode_switch_o != 5'h00))
    else $error("mid-level node left undriven");
  chk_ref_alone: assert property (internal_reference_switch_o |-> electrode_switch_o == 5'h00)
    else $error("reference switch closed with an electrode");
  chk_power_off_open: assert property (!block_power_enable_o && !$past(block_power_enable_o)
    |-> !external_path_switch_o && !internal_reference_switch_o && electrode_switch_o == 5'h00)
    else $error("path closed while powered down");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  chk_miso_idle: assert property (cs_n [*5] |-> !miso)
    else $error("device data not low outside a frame");
  chk_sclk_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high time wrong");
  chk_frame_len: assert property ($rose(cs_n) |-> rises == 6'h20 || rises == 6'h24)
    else $error("frame clock count wrong");
  chk_dac_step: assert property ($changed(cal_dac_code_o) |-> rises == 6'h24)
    else $error("DAC code changed before fourth extra clock");
endmodule : cmc_chk

// *** cmc_tb_top.sv ***
`timescale 1ns/100ps
module cmc_tb_top;
  import cmc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic drive_loop_open_i = 1'b0;
  logic [NUM_FACTORY_GAINS-1:0][COEF_W-1:0] factory_coef_i = {16'h1000, 16'h6000, 16'h2000};
  logic ecg_valid_i = 1'b0;
  logic [2:0] ecg_chan_i = 3'h0;
  logic signed [DATA_W-1:0] ecg_data_i = 24'h000000;
  logic req_i = 1'b0;
  logic write_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = 7'h00;
  logic [DATA_W-1:0] wdata_i = 24'h000000;
  logic busy_o, done_o, block_power_enable_o, external_path_switch_o, internal_reference_switch_o;
  logic [DATA_W-1:0] rdata_o;
  logic [NUM_ELEC-1:0] electrode_switch_o, drive_route_o;
  logic common_electrode_enable_o, header_fault_o, cal_square_o, cal_to_pin_o, ecg_valid_o;
  logic [DAC_W-1:0] cal_dac_code_o;
  logic [1:0] cal_tone_sel_o;
  logic [2:0] ecg_chan_o;
  logic signed [DATA_W-1:0] ecg_data_o;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [23:0] cm_tab [8] = '{24'h000000, 24'h000008, 24'h080000, 24'h180000,
                              24'h380000, 24'hF80100, 24'hF8000C, 24'h380008};
  logic [12:0] sw_tab [8] = '{13'h0400, 13'h0400, 13'h0020, 13'h0060,
                              13'h00E0, 13'h13E0, 13'h0800, 13'h0407};
  logic [23:0] gain_exp [4] = '{24'hFFFE0C, 24'hFFFA24, 24'hFFFF06, 24'hFFFC18};

  always #20 clk_i = ~clk_i;

  cmc_link_if u_cmc_link_if ();
  cmc_device #(.TONE_HALF_CYCLES(8)) u_cmc_device (.clk_i(clk_i), .rst_i(rst_i), .link(u_cmc_link_if),
    .drive_loop_open_i(drive_loop_open_i), .factory_coef_i(factory_coef_i), .ecg_valid_i(ecg_valid_i),
    .ecg_chan_i(ecg_chan_i), .ecg_data_i(ecg_data_i), .block_power_enable_o(block_power_enable_o),
    .external_path_switch_o(external_path_switch_o), .internal_reference_switch_o(internal_reference_switch_o),
    .electrode_switch_o(electrode_switch_o), .drive_route_o(drive_route_o),
    .common_electrode_enable_o(common_electrode_enable_o), .header_fault_o(header_fault_o),
    .cal_dac_code_o(cal_dac_code_o), .cal_tone_sel_o(cal_tone_sel_o), .cal_square_o(cal_square_o),
    .cal_to_pin_o(cal_to_pin_o), .ecg_valid_o(ecg_valid_o), .ecg_chan_o(ecg_chan_o), .ecg_data_o(ecg_data_o));
  cmc_host u_cmc_host (.clk_i(clk_i), .rst_i(rst_i), .link(u_cmc_link_if), .req_i(req_i), .write_i(write_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
  cmc_chk u_cmc_chk (.clk_i(clk_i), .rst_i(rst_i), .sclk(u_cmc_link_if.sclk), .cs_n(u_cmc_link_if.cs_n),
    .miso(u_cmc_link_if.miso), .block_power_enable_o(block_power_enable_o),
    .external_path_switch_o(external_path_switch_o), .internal_reference_switch_o(internal_reference_switch_o),
    .electrode_switch_o(electrode_switch_o), .cal_dac_code_o(cal_dac_code_o));

  ////////////////////////////////////////////////////////////////
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : compare

  // Request held until the host shows busy; done is a one-cycle pulse
  task automatic xfer(input logic w, input logic [6:0] a, input logic [23:0] d);
    @(negedge clk_i);
    req_i = 1'b1;
    write_i = w;
    addr_i = a;
    wdata_i = d;
    while (done_o !== 1'b1) begin
      @(negedge clk_i);
      if (busy_o === 1'b1) req_i = 1'b0;
    end
  endtask : xfer

  task automatic sample(input logic [2:0] ch, input logic [23:0] e);
    @(negedge clk_i);
    ecg_valid_i = 1'b1;
    ecg_chan_i = ch;
    ecg_data_i = 24'hFFFC18;
    // Output stands for one cycle only, so look before the next edge clears it
    @(negedge clk_i);
    compare(ecg_data_o, e);
    compare({20'h00000, ecg_valid_o, ecg_chan_o}, {20'h00000, 1'b1, ch});
    ecg_valid_i = 1'b0;
  endtask : sample

  ////////////////////////////////////////////////////////////////
  task automatic t_select;
    xfer(1'b1, ADDR_CHANNEL_CONTROL, 24'h000001);
    compare({23'h000000, block_power_enable_o}, 24'h000001);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, ADDR_CM_REF_CONTROL, cm_tab[i]);
      compare({11'h000, common_electrode_enable_o, external_path_switch_o, internal_reference_switch_o,
        electrode_switch_o, drive_route_o}, {11'h000, sw_tab[i]});
    end
    xfer(1'b1, ADDR_CHANNEL_CONTROL, 24'h000000);
    compare({11'h000, common_electrode_enable_o, external_path_switch_o, internal_reference_switch_o,
      electrode_switch_o, drive_route_o}, 24'h000000);
    xfer(1'b0, ADDR_CM_REF_CONTROL, 24'h000000);
    compare(rdata_o, 24'h380008);
    xfer(1'b0, 7'h7F, 24'h000000);
    compare(rdata_o, 24'h000000);
  endtask : t_select

  task automatic t_dac;
    logic s;
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, ADDR_CAL_DAC, {7'h00, m[0], 2'h0, m[1:0], 2'h0, {5{m[1:0]}}});
      compare({11'h000, cal_to_pin_o, cal_tone_sel_o, cal_dac_code_o}, {11'h000, m[0], m[1:0], {5{m[1:0]}}});
    end
    s = cal_square_o;
    // Eight edges always hold exactly one toggle of the tone
    repeat (8) @(negedge clk_i);
    compare({23'h000000, cal_square_o}, {23'h000000, ~s});
  endtask : t_dac

  task automatic t_gain;
    for (int g = 0; g < 4; g++) begin
      xfer(1'b1, ADDR_CHANNEL_CONTROL, {14'h0000, g[1:0], 8'h01});
      sample(g[2:0], gain_exp[g]);
    end
    xfer(1'b1, ADDR_GAIN_BASE + 7'h02, 24'h802000);
    sample(3'h2, 24'hFFFE0C);
    sample(3'h0, 24'hFFFC18);
    xfer(1'b0, ADDR_GAIN_BASE + 7'h02, 24'h000000);
    compare(rdata_o, 24'h802000);
  endtask : t_gain

  task automatic t_fault;
    xfer(1'b1, ADDR_CM_REF_CONTROL, 24'h080008);
    drive_loop_open_i = 1'b1;
    repeat (4) @(negedge clk_i);
    compare({19'h00000, drive_route_o}, 24'h000001);
    compare({23'h000000, header_fault_o}, 24'h000001);
    xfer(1'b0, ADDR_STATUS, 24'h000000);
    compare(rdata_o, 24'h000001);
    drive_loop_open_i = 1'b0;
    repeat (4) @(negedge clk_i);
    compare({23'h000000, header_fault_o}, 24'h000000);
  endtask : t_fault

  // Whole run needs about 6,500 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      $display("BAD %0t run did not finish", $time);
      finish_test();
    end
  end

  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    compare({external_path_switch_o, internal_reference_switch_o, electrode_switch_o, drive_route_o,
      block_power_enable_o, common_electrode_enable_o, cal_dac_code_o}, 24'h000000);
    repeat (4) @(negedge clk_i);
    t_select();
    t_dac();
    t_gain();
    t_fault();
    finish_test();
  end
endmodule : cmc_tb_top
